//--- hw/cfa_pkg.sv
// package: constants and types for the core flag and data-addressing block
package cfa_pkg;

  // apb byte offsets, one aligned word per register
  localparam logic [7:0] REG_FLAGS_OFS   = 8'h00;
  localparam logic [7:0] REG_WORK_OFS    = 8'h04;
  localparam logic [7:0] REG_BANK_OFS    = 8'h08;
  localparam logic [7:0] REG_SAVED_W_OFS = 8'h0C;
  localparam logic [7:0] REG_SAVED_B_OFS = 8'h10;
  localparam logic [7:0] REG_SAVED_F_OFS = 8'h14;
  localparam logic [7:0] REG_PTR0_OFS    = 8'h18;
  localparam logic [7:0] REG_PTR1_OFS    = 8'h1C;
  localparam logic [7:0] REG_PTR2_OFS    = 8'h20;
  localparam logic [7:0] REG_CONFIG_OFS  = 8'h24;

  // flag register bit positions, plus the extended-isa bit of the config register
  localparam int unsigned CARRY_BIT            = 0;
  localparam int unsigned DIGIT_CARRY_BIT      = 1;
  localparam int unsigned ZERO_BIT             = 2;
  localparam int unsigned SIGNED_OVERFLOW_BIT  = 3;
  localparam int unsigned NEGATIVE_BIT         = 4;
  localparam int unsigned POWER_DOWN_BIT       = 5;
  localparam int unsigned WATCHDOG_TIMEOUT_BIT = 6;
  localparam int unsigned EXT_ISA_BIT          = 0;

  // values after reset
  localparam logic [7:0]  FLAGS_RST = 8'h60;
  localparam logic [7:0]  WORK_RST  = 8'h00;
  localparam logic [5:0]  BANK_RST  = 6'h00;
  localparam logic [13:0] PTR_RST   = 14'h0000;
  localparam logic        EXT_RST   = 1'b0;

  // access-bank map and the flag register's place in data memory
  localparam logic [7:0]  ACCESS_SPLIT     = 8'h60;
  localparam logic [5:0]  ACCESS_HIGH_BANK = 6'h3F;
  localparam logic [13:0] FLAG_DATA_ADDR   = 14'h3FC0;

  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_CLR, OP_MOVWF,
    OP_BCF, OP_BSF, OP_SWAP, OP_RLC, OP_RRC, OP_CALL, OP_WDT_CLEAR, OP_SLEEP
  } cfa_op_e;

  typedef enum logic [2:0] {
    IND_NONE, IND_PLAIN, IND_ACC_INC, IND_ACC_DEC, IND_INC_ACC, IND_PLUS_W
  } cfa_ind_e;

endpackage

//--- hw/cfa_core.sv
// core flag register, call context save and data address generation
//
// Contract
// [RULE1] flag destination: apply flag effects, drop result
// [RULE2] bit, swap and move ops keep arithmetic flags
// [RULE3] subtract adds two's complement; carries mean no-borrow
// [RULE4] call saves working, bank and flag registers
// [RULE5] bit7 zero, timeout/power-down read-only, rest writable
// [RULE6] timeout flag: set by reset/clear/sleep, cleared by timeout
// [RULE7] power-down flag: set reset/clear, cleared by sleep
// [RULE8] negative flag copies result msb
// [RULE9] overflow flag on signed sign-bit change
// [RULE10] zero flag when result is zero
// [RULE11] digit carry from bit 3 on add/sub
// [RULE12] carry from msb on add/sub
// [RULE13] rotate loads carry with shifted-out bit
// [RULE14] access bit one: bank plus 8-bit address
// [RULE15] long address used directly, bank ignored
// [RULE16] destination bit picks file or working register
// [RULE17] call carries 20-bit target; inherent ops none
// [RULE18] three 14-bit pointers, two upper bits unused
// [RULE19] indirect operand accesses pointed location
// [RULE20] indirect address ignores bank and access bit
// [RULE21] indexed literal offset only with extended isa
// [RULE22] post-increment, post-decrement and pre-increment variants
// [RULE23] pointer plus signed working value, nothing changes
// [RULE24] pointer steps carry across bytes, flags untouched
// [RULE25] access bit zero maps onto fixed access window
// [RULE26] saved registers hold until next call
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module cfa_core #(
  parameter int unsigned PC_W = 20
) (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic                op_valid_i,
  input  cfa_pkg::cfa_op_e         op_i,
  input  wire logic [7:0]          file_addr_i,
  input  wire logic                access_bit_i,
  input  wire logic                dest_bit_i,
  input  wire logic                use_literal_i,
  input  wire logic [7:0]          literal_i,
  input  wire logic                long_addr_valid_i,
  input  wire logic [13:0]         long_addr_i,
  input  cfa_pkg::cfa_ind_e        ind_mode_i,
  input  wire logic [1:0]          ptr_sel_i,
  input  wire logic [2:0]          bit_sel_i,
  input  wire logic [PC_W-1:0]     call_target_i,
  input  wire logic                wdt_timeout_i,
  output logic      [13:0]         mem_addr_o,
  input  wire logic [7:0]          mem_rdata_i,
  output logic                     mem_we_o,
  output logic      [13:0]         mem_waddr_o,
  output logic      [7:0]          mem_wdata_o,
  output logic                     prog_load_o,
  output logic      [PC_W-1:0]     prog_target_o,
  output logic      [7:0]          flags_o
);

  logic [7:0]  flags;
  logic [7:0]  working_register;
  logic [5:0]  bank_select_register;
  logic [7:0]  call_saved_working_reg;
  logic [5:0]  call_saved_bank_select;
  logic [7:0]  call_saved_flags;
  logic [13:0] ptr [3];
  logic        extended_isa_config_bit;

  logic [13:0] ptr_cur;
  logic [13:0] ind_addr;
  logic [13:0] dir_addr;
  logic [13:0] eff_addr;
  logic [13:0] w_sext;
  logic [7:0]  src;
  logic [7:0]  addend;
  logic        carry_in;
  logic [8:0]  sum9;
  logic [4:0]  low5;
  logic [7:0]  res;
  logic [4:0]  arith_flags;
  logic        affects;
  logic        alu_op;
  logic        dest_file;
  logic        to_flags;
  logic        write_w;
  logic [7:0]  next_flags;

  logic        apb_setup;
  logic        apb_write;
  logic        addr_mapped;
  logic [31:0] rd_val;

  assign w_sext = {{6{working_register[7]}}, working_register};

  always_comb begin
    case (ptr_sel_i)
      2'h0:    ptr_cur = ptr[0];
      2'h1:    ptr_cur = ptr[1];
      2'h2:    ptr_cur = ptr[2];
      default: ptr_cur = 14'h0000;
    endcase
  end

  // indirect target is built from the pointer, never the bank
  always_comb begin
    case (ind_mode_i)
      cfa_pkg::IND_INC_ACC: ind_addr = ptr_cur + 14'h0001; // [RULE22]
      cfa_pkg::IND_PLUS_W:  ind_addr = ptr_cur + w_sext;   // [RULE23]
      default:              ind_addr = ptr_cur;            // [RULE19] [RULE20]
    endcase
  end

  always_comb begin
    if (access_bit_i) begin
      dir_addr = {bank_select_register, file_addr_i}; // [RULE14]
    end else if (file_addr_i < cfa_pkg::ACCESS_SPLIT) begin
      if (extended_isa_config_bit) begin
        dir_addr = ptr[2] + {6'h00, file_addr_i}; // [RULE21]
      end else begin
        dir_addr = {6'h00, file_addr_i}; // [RULE25]
      end
    end else begin
      dir_addr = {cfa_pkg::ACCESS_HIGH_BANK, file_addr_i}; // [RULE25]
    end
  end

  always_comb begin
    if (ind_mode_i != cfa_pkg::IND_NONE) begin
      eff_addr = ind_addr; // [RULE20]
    end else if (long_addr_valid_i) begin
      eff_addr = long_addr_i; // [RULE15]
    end else begin
      eff_addr = dir_addr;
    end
  end

  // read address is combinational so the memory answers in the same cycle
  assign mem_addr_o = eff_addr;

  // the flag register sits in data space; reads see the live value
  always_comb begin
    if (use_literal_i) begin
      src = literal_i;
    end else if (eff_addr == cfa_pkg::FLAG_DATA_ADDR) begin
      src = flags;
    end else begin
      src = mem_rdata_i;
    end
  end

  assign carry_in = (op_i == cfa_pkg::OP_SUB);
  assign addend   = carry_in ? ~working_register : working_register; // [RULE3]
  assign sum9     = {1'b0, src} + {1'b0, addend} + {8'h00, carry_in};
  assign low5     = {1'b0, src[3:0]} + {1'b0, addend[3:0]} + {4'h0, carry_in};

  always_comb begin
    res         = src;
    arith_flags = flags[4:0];
    affects     = 1'b0;
    alu_op      = 1'b0;
    case (op_i)
      cfa_pkg::OP_ADD, cfa_pkg::OP_SUB: begin
        res     = sum9[7:0];
        affects = 1'b1;
        alu_op  = 1'b1;
        arith_flags[cfa_pkg::CARRY_BIT]       = sum9[8]; // [RULE12] [RULE3]
        arith_flags[cfa_pkg::DIGIT_CARRY_BIT] = low5[4]; // [RULE11] [RULE3]
        arith_flags[cfa_pkg::SIGNED_OVERFLOW_BIT] =
          (src[7] == addend[7]) && (sum9[7] != src[7]); // [RULE9]
      end
      cfa_pkg::OP_AND: begin
        res     = src & working_register;
        affects = 1'b1;
        alu_op  = 1'b1;
      end
      cfa_pkg::OP_IOR: begin
        res     = src | working_register;
        affects = 1'b1;
        alu_op  = 1'b1;
      end
      cfa_pkg::OP_XOR: begin
        res     = src ^ working_register;
        affects = 1'b1;
        alu_op  = 1'b1;
      end
      cfa_pkg::OP_CLR: begin
        res     = 8'h00;
        affects = 1'b1;
      end
      cfa_pkg::OP_MOVWF: begin
        res = working_register; // [RULE2]
      end
      cfa_pkg::OP_BCF: begin
        res            = src;
        res[bit_sel_i] = 1'b0; // [RULE2]
      end
      cfa_pkg::OP_BSF: begin
        res            = src;
        res[bit_sel_i] = 1'b1; // [RULE2]
      end
      cfa_pkg::OP_SWAP: begin
        res    = {src[3:0], src[7:4]}; // [RULE2]
        alu_op = 1'b1;
      end
      cfa_pkg::OP_RLC: begin
        res     = {src[6:0], flags[cfa_pkg::CARRY_BIT]};
        affects = 1'b1;
        alu_op  = 1'b1;
        arith_flags[cfa_pkg::CARRY_BIT] = src[7]; // [RULE13]
      end
      cfa_pkg::OP_RRC: begin
        res     = {flags[cfa_pkg::CARRY_BIT], src[7:1]};
        affects = 1'b1;
        alu_op  = 1'b1;
        arith_flags[cfa_pkg::CARRY_BIT] = src[0]; // [RULE13]
      end
      default: begin
        res = src;
      end
    endcase
    if (affects) begin
      arith_flags[cfa_pkg::ZERO_BIT]     = (res == 8'h00); // [RULE10]
      arith_flags[cfa_pkg::NEGATIVE_BIT] = res[7];         // [RULE8]
    end
  end

  // literal forms land in the working register, save clr, movwf, bcf and bsf, which always write the file
  always_comb begin
    case (op_i)
      cfa_pkg::OP_CLR, cfa_pkg::OP_MOVWF, cfa_pkg::OP_BCF, cfa_pkg::OP_BSF:
        dest_file = 1'b1; // [RULE16]
      default:
        dest_file = alu_op && dest_bit_i && !use_literal_i; // [RULE16]
    endcase
  end

  assign to_flags = dest_file && (eff_addr == cfa_pkg::FLAG_DATA_ADDR);
  assign write_w  = op_valid_i && alu_op && !dest_file; // [RULE16]

  always_comb begin
    next_flags = flags;
    if (op_valid_i && affects) begin
      next_flags[4:0] = arith_flags; // [RULE1]
    end else if (op_valid_i && to_flags) begin
      next_flags[4:0] = res[4:0]; // [RULE2]
    end else if (apb_write && (paddr_i == cfa_pkg::REG_FLAGS_OFS)) begin
      next_flags[4:0] = pwdata_i[4:0]; // [RULE5]
    end
    // an explicit clear beats a simultaneous timeout so software sees it served
    if (op_valid_i && (op_i == cfa_pkg::OP_WDT_CLEAR || op_i == cfa_pkg::OP_SLEEP)) begin
      next_flags[cfa_pkg::WATCHDOG_TIMEOUT_BIT] = 1'b1; // [RULE6]
    end else if (wdt_timeout_i) begin
      next_flags[cfa_pkg::WATCHDOG_TIMEOUT_BIT] = 1'b0; // [RULE6]
    end
    if (op_valid_i && op_i == cfa_pkg::OP_WDT_CLEAR) begin
      next_flags[cfa_pkg::POWER_DOWN_BIT] = 1'b1; // [RULE7]
    end else if (op_valid_i && op_i == cfa_pkg::OP_SLEEP) begin
      next_flags[cfa_pkg::POWER_DOWN_BIT] = 1'b0; // [RULE7]
    end
    next_flags[7] = 1'b0; // [RULE5]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= cfa_pkg::FLAGS_RST; // [RULE6] [RULE7]
    end else begin
      flags <= next_flags;
    end
  end

  // core writes win over a software write in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      working_register <= cfa_pkg::WORK_RST;
    end else if (write_w) begin
      working_register <= res;
    end else if (apb_write && (paddr_i == cfa_pkg::REG_WORK_OFS)) begin
      working_register <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_select_register <= cfa_pkg::BANK_RST;
    end else if (apb_write && (paddr_i == cfa_pkg::REG_BANK_OFS)) begin
      bank_select_register <= pwdata_i[5:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      extended_isa_config_bit <= cfa_pkg::EXT_RST;
    end else if (apb_write && (paddr_i == cfa_pkg::REG_CONFIG_OFS)) begin
      extended_isa_config_bit <= pwdata_i[cfa_pkg::EXT_ISA_BIT];
    end
  end

  // pointer steps wrap the whole 14 bits and never reach the flags
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 3; i++) begin
        ptr[i] <= cfa_pkg::PTR_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (op_valid_i && ptr_sel_i == 2'(i) &&
            (ind_mode_i == cfa_pkg::IND_ACC_INC || ind_mode_i == cfa_pkg::IND_INC_ACC)) begin
          ptr[i] <= ptr[i] + 14'h0001; // [RULE22] [RULE24]
        end else if (op_valid_i && ptr_sel_i == 2'(i) &&
                     ind_mode_i == cfa_pkg::IND_ACC_DEC) begin
          ptr[i] <= ptr[i] - 14'h0001; // [RULE22] [RULE24]
        end else if (apb_write && paddr_i == cfa_pkg::REG_PTR0_OFS + 8'(4 * i)) begin
          ptr[i] <= pwdata_i[13:0]; // [RULE18]
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      call_saved_working_reg <= cfa_pkg::WORK_RST;
      call_saved_bank_select <= cfa_pkg::BANK_RST;
      call_saved_flags       <= cfa_pkg::FLAGS_RST;
    end else if (op_valid_i && op_i == cfa_pkg::OP_CALL) begin
      call_saved_working_reg <= working_register;     // [RULE4] [RULE26]
      call_saved_bank_select <= bank_select_register; // [RULE4] [RULE26]
      call_saved_flags       <= flags;                // [RULE4] [RULE26]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_load_o   <= 1'b0;
      prog_target_o <= '0;
    end else begin
      prog_load_o <= op_valid_i && op_i == cfa_pkg::OP_CALL;
      if (op_valid_i && op_i == cfa_pkg::OP_CALL) begin
        prog_target_o <= call_target_i; // [RULE17]
      end
    end
  end

  // a write aimed at the flag register never reaches memory
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_we_o    <= 1'b0;
      mem_waddr_o <= 14'h0000;
      mem_wdata_o <= 8'h00;
    end else begin
      mem_we_o <= op_valid_i && dest_file && !to_flags; // [RULE1] [RULE16]
      if (op_valid_i && dest_file) begin
        mem_waddr_o <= eff_addr;
        mem_wdata_o <= res;
      end
    end
  end

  assign flags_o = flags;

  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pready_o && pwrite_i && addr_mapped;
  assign pready_o  = 1'b1;

  always_comb begin
    addr_mapped = 1'b1;
    case (paddr_i)
      cfa_pkg::REG_FLAGS_OFS:   rd_val = {24'h000000, 1'b0, flags[6:0]}; // [RULE5]
      cfa_pkg::REG_WORK_OFS:    rd_val = {24'h000000, working_register};
      cfa_pkg::REG_BANK_OFS:    rd_val = {26'h0000000, bank_select_register};
      cfa_pkg::REG_SAVED_W_OFS: rd_val = {24'h000000, call_saved_working_reg};
      cfa_pkg::REG_SAVED_B_OFS: rd_val = {26'h0000000, call_saved_bank_select};
      cfa_pkg::REG_SAVED_F_OFS: rd_val = {24'h000000, call_saved_flags};
      cfa_pkg::REG_PTR0_OFS:    rd_val = {18'h00000, ptr[0]}; // [RULE18]
      cfa_pkg::REG_PTR1_OFS:    rd_val = {18'h00000, ptr[1]};
      cfa_pkg::REG_PTR2_OFS:    rd_val = {18'h00000, ptr[2]};
      cfa_pkg::REG_CONFIG_OFS:  rd_val = {31'h00000000, extended_isa_config_bit};
      default: begin
        rd_val      = 32'h00000000;
        addr_mapped = 1'b0;
      end
    endcase
  end

  // read data is caught in setup so the access phase needs no wait state
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (apb_setup) begin
      prdata_o  <= pwrite_i ? 32'h00000000 : rd_val;
      pslverr_o <= !addr_mapped;
    end
  end

endmodule // cfa_core

//--- verif/cfa_core_props.sv
// checker: port-level assertions for the core flag and addressing block
`timescale 1ns/1ps
module cfa_core_chk #(
  parameter int unsigned PC_W = 20
) (
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            psel_i,
  input  wire logic            penable_i,
  input  wire logic            pwrite_i,
  input  wire logic            op_valid_i,
  input  cfa_pkg::cfa_op_e     op_i,
  input  wire logic [7:0]      file_addr_i,
  input  wire logic            access_bit_i,
  input  wire logic            long_addr_valid_i,
  input  wire logic [13:0]     long_addr_i,
  input  cfa_pkg::cfa_ind_e    ind_mode_i,
  input  wire logic [PC_W-1:0] call_target_i,
  input  wire logic            wdt_timeout_i,
  input  wire logic [13:0]     mem_addr_o,
  input  wire logic            prog_load_o,
  input  wire logic [PC_W-1:0] prog_target_o,
  input  wire logic [7:0]      flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic dir_op;
  // direct addressing only when neither pointer nor long address is in play
  assign dir_op = op_valid_i && ind_mode_i == cfa_pkg::IND_NONE && !long_addr_valid_i;

  chk_call_load: assert property (
    op_valid_i && op_i == cfa_pkg::OP_CALL |=>
      prog_load_o && prog_target_o == $past(call_target_i))
    else $error("call target not loaded");
  chk_load_cause: assert property (
    prog_load_o |-> $past(op_valid_i && op_i == cfa_pkg::OP_CALL))
    else $error("program load without call");
  chk_bit7_zero: assert property (flags_o[7] == 1'b0)
    else $error("flag bit 7 not zero");
  chk_sleep_flags: assert property (
    op_valid_i && op_i == cfa_pkg::OP_SLEEP |=> flags_o[6:5] == 2'b10)
    else $error("sleep status bits wrong");
  chk_clear_flags: assert property (
    op_valid_i && op_i == cfa_pkg::OP_WDT_CLEAR |=> flags_o[6:5] == 2'b11)
    else $error("watchdog clear status bits wrong");
  chk_timeout_clr: assert property (
    wdt_timeout_i && !(op_valid_i && op_i inside {cfa_pkg::OP_SLEEP,
      cfa_pkg::OP_WDT_CLEAR}) |=> !flags_o[6])
    else $error("timeout bit not cleared");
  chk_long_addr: assert property (
    op_valid_i && ind_mode_i == cfa_pkg::IND_NONE && long_addr_valid_i
      |-> mem_addr_o == long_addr_i)
    else $error("long address not used");
  chk_bank_addr: assert property (
    dir_op && access_bit_i |-> mem_addr_o[7:0] == file_addr_i)
    else $error("banked low byte wrong");
  chk_access_high: assert property (
    dir_op && !access_bit_i && file_addr_i >= 8'h60
      |-> mem_addr_o == {6'h3F, file_addr_i})
    else $error("access window address wrong");
  chk_neutral_ops: assert property (
    op_valid_i && op_i inside {cfa_pkg::OP_BCF, cfa_pkg::OP_BSF, cfa_pkg::OP_SWAP,
      cfa_pkg::OP_MOVWF} && mem_addr_o != cfa_pkg::FLAG_DATA_ADDR
      && !(psel_i && penable_i && pwrite_i) |=> $stable(flags_o[4:0]))
    else $error("flag-neutral op changed flags");
endmodule  // cfa_core_chk

bind cfa_core cfa_core_chk #(.PC_W(PC_W)) i_cfa_core_chk (.clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .op_valid_i, .op_i, .file_addr_i, .access_bit_i,
  .long_addr_valid_i, .long_addr_i, .ind_mode_i, .call_target_i, .wdt_timeout_i,
  .mem_addr_o, .prog_load_o, .prog_target_o, .flags_o);

//--- verif/cfa_mem_model.sv
// partner: behavioural data memory array beside the core
`timescale 1ns/1ps
module cfa_mem_model (
  input  wire logic        clk_i,
  input  wire logic [13:0] addr_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        we_i,
  input  wire logic [13:0] waddr_i,
  input  wire logic [7:0]  wdata_i
);
  logic [7:0] mem [16384];
  // read follows the address within the cycle, as the core samples it then
  assign rdata_o = mem[addr_i];
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule  // cfa_mem_model

//--- verif/test_core_flags_and_data_addressing.sv
// testbench: table and hand checks of the flag and addressing core
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("BAD %s exp %0h got %0h", n, e, g); \
  end \
end
module test_core_flags_and_data_addressing;
  logic              clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic              pwrite_i = 1'b0, op_valid_i = 1'b0, access_bit_i = 1'b0;
  logic              dest_bit_i = 1'b0, use_literal_i = 1'b0, long_addr_valid_i = 1'b0;
  logic              wdt_timeout_i = 1'b0, pready_o, pslverr_o, mem_we_o, prog_load_o;
  logic              er, we;
  logic [7:0]        paddr_i = 8'h00, file_addr_i = 8'h00, literal_i = 8'h00;
  logic [7:0]        mem_rdata_i, mem_wdata_o, flags_o, wd;
  logic [31:0]       pwdata_i = 32'h0, prdata_o, rd;
  logic [13:0]       long_addr_i = 14'h0, mem_addr_o, mem_waddr_o, ea;
  logic [1:0]        ptr_sel_i = 2'h0;
  logic [2:0]        bit_sel_i = 3'h0;
  logic [19:0]       call_target_i = 20'h0, prog_target_o;
  cfa_pkg::cfa_op_e  op_i = cfa_pkg::OP_NONE;
  cfa_pkg::cfa_ind_e ind_mode_i = cfa_pkg::IND_NONE;
  int                n_mismatch = 0, cmp_count = 0;
  typedef struct {
    cfa_pkg::cfa_op_e o;
    logic [2:0]       b;
    logic [7:0]       f, w, pre, res, post;
  } cfa_row_s;
  // op, bit, file value, working, flags before, result, flags after
  cfa_row_s tbl [15] = '{
    '{cfa_pkg::OP_ADD, 3'h0, 8'h7F, 8'h01, 8'h00, 8'h80, 8'h1A},
    '{cfa_pkg::OP_ADD, 3'h0, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h07},
    '{cfa_pkg::OP_SUB, 3'h0, 8'h05, 8'h05, 8'h00, 8'h00, 8'h07},
    '{cfa_pkg::OP_SUB, 3'h0, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h10},
    '{cfa_pkg::OP_SUB, 3'h0, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h09},
    '{cfa_pkg::OP_AND, 3'h0, 8'hF0, 8'h0F, 8'h0B, 8'h00, 8'h0F},
    '{cfa_pkg::OP_XOR, 3'h0, 8'hFF, 8'h0F, 8'h03, 8'hF0, 8'h13},
    '{cfa_pkg::OP_IOR, 3'h0, 8'h00, 8'h00, 8'h10, 8'h00, 8'h04},
    '{cfa_pkg::OP_RLC, 3'h0, 8'h80, 8'h00, 8'h00, 8'h00, 8'h05},
    '{cfa_pkg::OP_RRC, 3'h0, 8'h01, 8'h00, 8'h01, 8'h80, 8'h11},
    '{cfa_pkg::OP_BSF, 3'h3, 8'h00, 8'h00, 8'h1F, 8'h08, 8'h1F},
    '{cfa_pkg::OP_BCF, 3'h0, 8'hFF, 8'h00, 8'h0A, 8'hFE, 8'h0A},
    '{cfa_pkg::OP_SWAP, 3'h0, 8'h12, 8'h00, 8'h15, 8'h21, 8'h15},
    '{cfa_pkg::OP_MOVWF, 3'h0, 8'h00, 8'h3C, 8'h07, 8'h3C, 8'h07},
    '{cfa_pkg::OP_CLR, 3'h0, 8'h55, 8'h00, 8'h13, 8'h00, 8'h07}};
  cfa_pkg::cfa_ind_e im [5] = '{cfa_pkg::IND_ACC_INC, cfa_pkg::IND_INC_ACC,
    cfa_pkg::IND_ACC_DEC, cfa_pkg::IND_PLUS_W, cfa_pkg::IND_PLAIN};
  logic [13:0] iea [5] = '{14'h00FF, 14'h0101, 14'h0101, 14'h00FF, 14'h0100};
  logic [13:0] ipt [5] = '{14'h0100, 14'h0101, 14'h0100, 14'h0100, 14'h0100};
  logic [7:0]  sav [3] = '{8'h5A, 8'h2B, 8'h69};

  cfa_core #(.PC_W(20)) i_cfa_core (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .op_valid_i, .op_i,
    .file_addr_i, .access_bit_i, .dest_bit_i, .use_literal_i, .literal_i,
    .long_addr_valid_i, .long_addr_i, .ind_mode_i, .ptr_sel_i, .bit_sel_i,
    .call_target_i, .wdt_timeout_i, .mem_addr_o, .mem_rdata_i, .mem_we_o,
    .mem_waddr_o, .mem_wdata_o, .prog_load_o, .prog_target_o, .flags_o);
  cfa_mem_model i_cfa_mem_model (.clk_i, .addr_i(mem_addr_o), .rdata_o(mem_rdata_i),
    .we_i(mem_we_o), .waddr_i(mem_waddr_o), .wdata_i(mem_wdata_o));

  always #20 clk_i = ~clk_i;

  // an idle edge after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic issue(input cfa_pkg::cfa_op_e o, input logic [7:0] f, input logic a,
                       input logic d);
    op_valid_i <= 1'b1;
    op_i <= o;
    file_addr_i <= f;
    access_bit_i <= a;
    dest_bit_i <= d;
    #1 ea = mem_addr_o;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1 we = mem_we_o;
    wd = mem_wdata_o;
    @(posedge clk_i);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int a = 0; a < 10; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      `CHK("reset value", (a == 0 || a == 5) ? 32'h60 : 32'h0, rd)
    end
    apb(1'b1, cfa_pkg::REG_FLAGS_OFS, 32'hFF);
    apb(1'b0, cfa_pkg::REG_FLAGS_OFS, 32'h0);
    `CHK("flag write", 32'h7F, rd)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    $display("register test done");
    foreach (tbl[i]) begin
      apb(1'b1, cfa_pkg::REG_WORK_OFS, {24'h0, tbl[i].w});
      apb(1'b1, cfa_pkg::REG_FLAGS_OFS, {24'h0, tbl[i].pre});
      i_cfa_mem_model.mem[14'h0010] = tbl[i].f;
      bit_sel_i <= tbl[i].b;
      issue(tbl[i].o, 8'h10, 1'b1, 1'b1);
      `CHK("write strobe", 1'b1, we)
      `CHK("result", tbl[i].res, wd)
      `CHK("write addr", 14'h0010, mem_waddr_o)
      apb(1'b0, cfa_pkg::REG_FLAGS_OFS, 32'h0);
      `CHK("flags", {24'h0, 8'h60 | tbl[i].post}, rd)
    end
    $display("alu table done");
    apb(1'b1, cfa_pkg::REG_FLAGS_OFS, 32'h0);
    apb(1'b1, cfa_pkg::REG_WORK_OFS, 32'hA0);
    i_cfa_mem_model.mem[cfa_pkg::FLAG_DATA_ADDR] = 8'h00;
    issue(cfa_pkg::OP_ADD, 8'hC0, 1'b0, 1'b1);
    `CHK("flag dest addr", cfa_pkg::FLAG_DATA_ADDR, ea)
    `CHK("flag dest strobe", 1'b0, we)
    apb(1'b0, cfa_pkg::REG_FLAGS_OFS, 32'h0);
    `CHK("flag dest flags", 32'h65, rd)
    apb(1'b1, cfa_pkg::REG_WORK_OFS, 32'h01);
    i_cfa_mem_model.mem[14'h0010] = 8'h02;
    issue(cfa_pkg::OP_ADD, 8'h10, 1'b1, 1'b0);
    `CHK("work dest strobe", 1'b0, we)
    apb(1'b0, cfa_pkg::REG_WORK_OFS, 32'h0);
    `CHK("work dest value", 32'h03, rd)
    $display("destination test done");
    apb(1'b1, cfa_pkg::REG_WORK_OFS, 32'h5A);
    apb(1'b1, cfa_pkg::REG_BANK_OFS, 32'h2B);
    apb(1'b1, cfa_pkg::REG_FLAGS_OFS, 32'h09);
    call_target_i <= 20'hABCDE;
    issue(cfa_pkg::OP_CALL, 8'h00, 1'b0, 1'b0);
    `CHK("call target", 20'hABCDE, prog_target_o)
    apb(1'b1, cfa_pkg::REG_WORK_OFS, 32'hFF);
    apb(1'b1, cfa_pkg::REG_SAVED_W_OFS, 32'h11);
    for (int s = 0; s < 3; s++) begin
      apb(1'b0, 8'(cfa_pkg::REG_SAVED_W_OFS + 8'(s * 4)), 32'h0);
      `CHK("saved reg", {24'h0, sav[s]}, rd)
    end
    issue(cfa_pkg::OP_MOVWF, 8'h10, 1'b1, 1'b1);
    `CHK("banked addr", 14'h2B10, ea)
    long_addr_valid_i <= 1'b1;
    long_addr_i <= 14'h2345;
    issue(cfa_pkg::OP_MOVWF, 8'h10, 1'b1, 1'b1);
    `CHK("long addr", 14'h2345, ea)
    long_addr_valid_i <= 1'b0;
    issue(cfa_pkg::OP_MOVWF, 8'h05, 1'b0, 1'b1);
    `CHK("access low addr", 14'h0005, ea)
    apb(1'b1, cfa_pkg::REG_CONFIG_OFS, 32'h1);
    apb(1'b1, cfa_pkg::REG_PTR2_OFS, 32'h0200);
    issue(cfa_pkg::OP_MOVWF, 8'h05, 1'b0, 1'b1);
    `CHK("indexed addr", 14'h0205, ea)
    apb(1'b1, cfa_pkg::REG_CONFIG_OFS, 32'h0);
    $display("addressing test done");
    apb(1'b1, cfa_pkg::REG_PTR0_OFS, 32'h00FF);
    for (int i = 0; i < 5; i++) begin
      ind_mode_i <= im[i];
      issue(cfa_pkg::OP_MOVWF, 8'h33, 1'b1, 1'b1);
      `CHK("indirect addr", iea[i], ea)
      apb(1'b0, cfa_pkg::REG_PTR0_OFS, 32'h0);
      `CHK("pointer", {18'h0, ipt[i]}, rd)
    end
    ind_mode_i <= cfa_pkg::IND_NONE;
    $display("indirect test done");
    issue(cfa_pkg::OP_SLEEP, 8'h00, 1'b0, 1'b0);
    `CHK("sleep bits", 2'b10, flags_o[6:5])
    wdt_timeout_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    @(posedge clk_i);
    `CHK("timeout bit", 1'b0, flags_o[6])
    issue(cfa_pkg::OP_WDT_CLEAR, 8'h00, 1'b0, 1'b0);
    `CHK("clear bits", 2'b11, flags_o[6:5])
    $display("power status test done");
    end_sim();
  end
endmodule  // test_core_flags_and_data_addressing
